// [inc/ibtq_pkg.sv]
// constants, register map and types of the image block transfer queue
// Functional notes
// RULE1: basic and automatic policies start a block once one packet of it is buffered.
// RULE2: the policy selector has exactly basic, automatic and host governed encodings.
// RULE3: host governed continuous style streams on go and halt while capture runs on.
// RULE4: counted burst style sends exactly blocks_to_send blocks and then stops.
// RULE5: blocks_to_send only matters in counted burst style.
// RULE6: queue_capacity reads the largest number of blocks the queue holds.
// RULE7: queue_occupancy always equals the blocks waiting in the queue.
// RULE8: lost_block_tally counts once for every block lost before transmission.
// RULE9: the ordering selector offers only arrival order.
// RULE10: the go command starts streaming, only under the host governed policy.
// RULE11: the halt command stops streaming after the current block completes.
// RULE12: a full queue drops its oldest unstarted block for the new one and counts it.
// RULE13: capture start or stop leaves the queue alone; closing the channel flushes it.
// RULE14: go and halt under basic or automatic policy are ignored.
package ibtq_pkg;
  localparam logic [7:0] OFS_POLICY = 8'h00;
  localparam logic [7:0] OFS_STYLE = 8'h04;
  localparam logic [7:0] OFS_BLOCKS = 8'h08;
  localparam logic [7:0] OFS_CAPACITY = 8'h0C;
  localparam logic [7:0] OFS_OCCUPANCY = 8'h10;
  localparam logic [7:0] OFS_LOST = 8'h14;
  localparam logic [7:0] OFS_ORDERING = 8'h18;
  localparam logic [7:0] OFS_COMMAND = 8'h1C;
  localparam logic [7:0] OFS_CHANNEL = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // command register bits
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_HALT_BIT = 1;
  // interrupt status bits
  localparam int IRQ_LOST_BIT = 0;
  localparam int IRQ_BURST_DONE_BIT = 1;
  localparam int IRQ_BLOCK_SENT_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  // reset values
  localparam logic [1:0] POLICY_RESET = 2'h0;
  localparam logic [31:0] BLOCKS_RESET = 32'h00000001;
  localparam logic [31:0] PKT_BEATS_DEFAULT = 32'h00000100;
  typedef enum logic [1:0] {
    IBTQ_BASIC = 2'h0,
    IBTQ_AUTOMATIC = 2'h1,
    IBTQ_HOST_GOVERNED = 2'h2
  } ibtq_policy_t;
  typedef enum logic {
    IBTQ_CONTINUOUS = 1'b0,
    IBTQ_COUNTED_BURST = 1'b1
  } ibtq_style_t;
  typedef enum logic [0:0] {
    IBTQ_ARRIVAL_ORDER = 1'b0
  } ibtq_ordering_t;
endpackage : ibtq_pkg

// [src/ibtq_slot_ring.sv]
// ring of block slots holding per-block beat counts, oldest first
module ibtq_slot_ring #(
  parameter int DEPTH = 4,
  parameter int CW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic push,
  input wire logic drop_oldest,
  input wire logic pop,
  input wire logic [CW-1:0] push_beats,
  output logic [CW-1:0] head_beats,
  output logic [$clog2(DEPTH+1)-1:0] count,
  output logic full,
  output logic empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [CW-1:0] slot_q [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_q;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign count = cnt_q;
  assign full = (cnt_q == ($clog2(DEPTH+1))'(DEPTH));
  assign empty = (cnt_q == '0);
  assign head_beats = slot_q[rd_q];

  // drop and pop never coincide: the caller only drops unstarted heads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= bump(wr_q);
      end
      if (pop || drop_oldest) begin
        rd_q <= bump(rd_q);
      end
      if (push && !(pop || drop_oldest)) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (!push && (pop || drop_oldest)) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // slot storage, no reset needed for data
  always_ff @(posedge pclk) begin
    if (push) begin
      slot_q[wr_q] <= push_beats;
    end
  end
endmodule : ibtq_slot_ring

// [src/ibtq_top.sv]
// image block transfer queue with APB registers and packet egress
module ibtq_top #(
  parameter int DEPTH = 4,
  parameter int CW = 16,
  parameter logic [CW-1:0] PKT_BEATS = CW'(ibtq_pkg::PKT_BEATS_DEFAULT)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic blk_beat_valid,
  input wire logic blk_beat_last,
  input wire logic capture_running,
  input wire logic link_pkt_ready,
  output logic link_pkt_valid,
  output logic link_pkt_last,
  output logic irq
);
  // apb decode
  logic wr_en;
  assign wr_en = psel && penable && pwrite;

  // software-held configuration
  logic [1:0] policy_q;
  logic style_q;
  logic [31:0] blocks_to_send_q;
  logic channel_open_q;
  logic [31:0] lost_block_tally_q;
  localparam int IRQ_W = ibtq_pkg::IRQ_WIDTH;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;

  function automatic logic legal_policy(input logic [1:0] v);
    legal_policy = (v == ibtq_pkg::IBTQ_BASIC) ||
                   (v == ibtq_pkg::IBTQ_AUTOMATIC) ||
                   (v == ibtq_pkg::IBTQ_HOST_GOVERNED);
  endfunction : legal_policy

  logic host_gov;
  assign host_gov = (policy_q == ibtq_pkg::IBTQ_HOST_GOVERNED);

  // commands act only under host governed policy
  logic go_cmd;
  logic halt_cmd;
  assign go_cmd = wr_en && (paddr == ibtq_pkg::OFS_COMMAND) && host_gov
                  && pwdata[ibtq_pkg::CMD_GO_BIT]; // RULE10 RULE14
  assign halt_cmd = wr_en && (paddr == ibtq_pkg::OFS_COMMAND) && host_gov
                    && pwdata[ibtq_pkg::CMD_HALT_BIT]; // RULE11 RULE14

  // configuration writes; illegal policy codes are kept out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      policy_q <= ibtq_pkg::POLICY_RESET;
      style_q <= ibtq_pkg::IBTQ_CONTINUOUS;
      blocks_to_send_q <= ibtq_pkg::BLOCKS_RESET;
      channel_open_q <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        ibtq_pkg::OFS_POLICY: begin
          if (legal_policy(pwdata[1:0])) begin
            policy_q <= pwdata[1:0]; // RULE2
          end
        end
        ibtq_pkg::OFS_STYLE: style_q <= pwdata[0]; // RULE3
        ibtq_pkg::OFS_BLOCKS: blocks_to_send_q <= pwdata;
        ibtq_pkg::OFS_CHANNEL: channel_open_q <= pwdata[0];
        default: ;
      endcase
    end
  end

  // closing the channel flushes; capture_running only shows in status
  logic flush;
  assign flush = !channel_open_q; // RULE13

  // ingress: a block arrives beat by beat, counted into a slot
  logic [CW-1:0] in_beats_q;
  logic in_active;
  logic blk_push;
  logic cut_live;
  logic [CW-1:0] blk_beats;
  // a block already streaming by cut-through is never queued again
  assign blk_push = blk_beat_valid && blk_beat_last && channel_open_q
                    && !cut_live;
  assign blk_beats = in_beats_q + 1'b1;

  // ingress beats counted per block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_beats_q <= '0;
    end else if (flush || (blk_beat_valid && blk_beat_last)) begin
      in_beats_q <= '0;
    end else if (blk_beat_valid) begin
      in_beats_q <= in_beats_q + 1'b1;
    end
  end

  // head of ingress block counts as live before it is queued
  assign in_active = (in_beats_q != '0);

  // egress state
  typedef enum {
    IBTQ_IDLE,
    IBTQ_SEND
  } ibtq_tx_state_t;
  ibtq_tx_state_t tx_q;
  logic streaming_q;
  logic [31:0] sent_q;
  logic [CW-1:0] tx_len_q;
  logic [CW-1:0] tx_sent_q;
  logic cut_q;
  logic cut_known_q;
  ibtq_tx_state_t tx_d;
  logic [CW-1:0] len_d;
  logic [CW-1:0] sent_d;
  logic [CW-1:0] avail_d;
  logic cut_d;
  logic known_d;
  logic beat_fire;

  // ring control
  logic [CW-1:0] head_beats;
  logic [$clog2(DEPTH+1)-1:0] occ;
  logic ring_full;
  logic ring_empty;
  logic pop;
  logic drop_oldest;
  logic tx_start;
  logic tx_done;
  logic cut_through;

  // full ring: overwrite oldest block not yet on the link
  // every queued block is unstarted, so a full ring drops its head unless that head pops in the same cycle
  assign drop_oldest = blk_push && ring_full && !pop; // RULE12
  // block leaves its slot when its transfer begins
  assign pop = tx_start;

  ibtq_slot_ring #(
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_ring (
    .pclk(pclk),
    .presetn(presetn),
    .flush(flush),
    .push(blk_push),
    .drop_oldest(drop_oldest),
    .pop(pop),
    .push_beats(blk_beats),
    .head_beats(head_beats),
    .count(occ),
    .full(ring_full),
    .empty(ring_empty)
  ); // RULE9

  // cut-through: in basic/automatic, start once a packet is buffered
  assign cut_through = !host_gov && channel_open_q && ring_empty
                       && (tx_q == IBTQ_IDLE) && in_active
                       && (in_beats_q >= PKT_BEATS)
                       && !(blk_beat_valid && blk_beat_last); // RULE1

  // streaming permission: outside host governed policy, on whenever the channel is open
  logic may_stream;
  assign may_stream = channel_open_q && (!host_gov || streaming_q);

  assign tx_start = (tx_q == IBTQ_IDLE) && may_stream && !ring_empty;
  assign beat_fire = link_pkt_valid && link_pkt_ready;
  assign tx_done = (tx_q == IBTQ_SEND) && beat_fire && link_pkt_last;
  assign cut_live = (tx_q == IBTQ_SEND) && cut_q && !cut_known_q;

  logic burst_end;
  assign burst_end = tx_done && host_gov
                     && (style_q == ibtq_pkg::IBTQ_COUNTED_BURST)
                     && (sent_q + 32'h00000001 >= blocks_to_send_q); // RULE4

  // host governed run flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      streaming_q <= 1'b0;
    end else if (flush || !host_gov) begin
      streaming_q <= 1'b0;
    end else if (go_cmd) begin
      streaming_q <= 1'b1; // RULE10 RULE3
    end else if (halt_cmd || burst_end) begin
      streaming_q <= 1'b0; // RULE11 RULE4
    end
  end

  // blocks sent since go, compared only in counted burst style
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_q <= '0;
    end else if (go_cmd || flush) begin
      sent_q <= '0;
    end else if (tx_done && style_q == ibtq_pkg::IBTQ_COUNTED_BURST) begin
      sent_q <= sent_q + 32'h00000001; // RULE5
    end
  end

  // egress next state; a cut-through block learns its length late
  always_comb begin
    tx_d = tx_q;
    len_d = tx_len_q;
    sent_d = tx_sent_q;
    cut_d = cut_q;
    known_d = cut_known_q;
    case (tx_q)
      IBTQ_IDLE: begin
        if (tx_start) begin
          tx_d = IBTQ_SEND;
          len_d = head_beats;
          sent_d = '0;
          cut_d = 1'b0;
          known_d = 1'b1;
        end else if (cut_through) begin
          tx_d = IBTQ_SEND; // RULE1
          len_d = '0;
          sent_d = '0;
          cut_d = 1'b1;
          known_d = 1'b0;
        end
      end
      IBTQ_SEND: begin
        if (beat_fire) begin
          sent_d = tx_sent_q + 1'b1;
        end
        if (cut_live && blk_beat_valid && blk_beat_last) begin
          len_d = in_beats_q + 1'b1;
          known_d = 1'b1;
        end
        if (tx_done) begin
          tx_d = IBTQ_IDLE; // RULE11
        end
      end
      default: tx_d = IBTQ_IDLE;
    endcase
    if (flush) begin
      tx_d = IBTQ_IDLE; // RULE13
    end
    // ingress count lags by a beat, which only delays an offer
    avail_d = known_d ? len_d : in_beats_q;
  end

  // egress fsm; halt never cuts a block short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= IBTQ_IDLE;
      tx_len_q <= '0;
      tx_sent_q <= '0;
      cut_q <= 1'b0;
      cut_known_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      tx_len_q <= len_d;
      tx_sent_q <= sent_d;
      cut_q <= cut_d;
      cut_known_q <= known_d;
    end
  end

  // link outputs registered; an offered beat stays until the link takes it or closing the channel flushes the egress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_pkt_valid <= 1'b0;
      link_pkt_last <= 1'b0;
    end else begin
      link_pkt_valid <= (tx_d == IBTQ_SEND) && (sent_d < avail_d);
      link_pkt_last <= (tx_d == IBTQ_SEND) && (sent_d < avail_d) && known_d
                       && (sent_d + 1'b1 == len_d);
    end
  end

  // lost block tally, saturating to avoid wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lost_block_tally_q <= '0;
    end else if (drop_oldest && lost_block_tally_q != 32'hFFFFFFFF) begin
      lost_block_tally_q <= lost_block_tally_q + 32'h00000001; // RULE8 RULE12
    end
  end

  // sticky interrupt status: a new event beats a clear
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_evt = '0;
    irq_evt[ibtq_pkg::IRQ_LOST_BIT] = drop_oldest;
    irq_evt[ibtq_pkg::IRQ_BURST_DONE_BIT] = burst_end;
    irq_evt[ibtq_pkg::IRQ_BLOCK_SENT_BIT] = tx_done;
    irq_clr = (wr_en && paddr == ibtq_pkg::OFS_IRQ_CLEAR)
              ? pwdata[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      if (wr_en && paddr == ibtq_pkg::OFS_IRQ_ENABLE) begin
        irq_en_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_q & ~irq_clr) | irq_evt) & irq_en_q);
    end
  end

  // apb read mux; zero-wait, unmapped reads give zero with error
  logic [31:0] rd_d;
  logic hit_d;
  always_comb begin
    rd_d = '0;
    hit_d = 1'b1;
    case (paddr)
      ibtq_pkg::OFS_POLICY: rd_d[1:0] = policy_q;
      ibtq_pkg::OFS_STYLE: rd_d[0] = style_q;
      ibtq_pkg::OFS_BLOCKS: rd_d = blocks_to_send_q;
      ibtq_pkg::OFS_CAPACITY: rd_d = 32'(DEPTH); // RULE6
      ibtq_pkg::OFS_OCCUPANCY: rd_d = 32'(occ); // RULE7
      ibtq_pkg::OFS_LOST: rd_d = lost_block_tally_q; // RULE8
      ibtq_pkg::OFS_ORDERING: rd_d[0] = ibtq_pkg::IBTQ_ARRIVAL_ORDER; // RULE9
      ibtq_pkg::OFS_COMMAND: rd_d = '0;
      ibtq_pkg::OFS_CHANNEL: rd_d[0] = channel_open_q;
      ibtq_pkg::OFS_IRQ_STATUS: rd_d[IRQ_W-1:0] = irq_stat_q;
      ibtq_pkg::OFS_IRQ_CLEAR: rd_d = '0;
      ibtq_pkg::OFS_IRQ_ENABLE: rd_d[IRQ_W-1:0] = irq_en_q;
      ibtq_pkg::OFS_STATUS: begin
        rd_d[0] = streaming_q;
        rd_d[1] = (tx_q == IBTQ_SEND);
        rd_d[2] = capture_running;
      end
      default: hit_d = 1'b0;
    endcase
  end

  // two-cycle access: pready rises at the edge that ends the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_d;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end
endmodule : ibtq_top

// [verification/ibtq_top_properties.sv]
// port-level assertions for the transfer queue
module ibtq_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic blk_beat_valid,
  input wire logic blk_beat_last,
  input wire logic capture_running,
  input wire logic link_pkt_ready,
  input wire logic link_pkt_valid,
  input wire logic link_pkt_last,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a setup cycle, and a beat the link refused
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_stall;
    link_pkt_valid && !link_pkt_ready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_needs_setup: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_zero_data: assert property (pslverr && !pwrite |-> prdata == 0)
    else $error("refused read returns data");
  a_valid_held: assert property (s_stall |=> link_pkt_valid)
    else $error("beat withdrawn");
  a_last_stable: assert property (s_stall |=> $stable(link_pkt_last))
    else $error("last flag moved while stalled");
  a_last_in_beat: assert property (link_pkt_last |-> link_pkt_valid)
    else $error("last flag without beat");
endmodule : ibtq_chk
bind ibtq_top ibtq_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .blk_beat_valid,
  .blk_beat_last, .capture_running, .link_pkt_ready, .link_pkt_valid,
  .link_pkt_last, .irq);

// [verification/ibtq_host_model.sv]
// host end of the stream link: takes beats, reports each block length
module ibtq_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold,
  input wire logic coin,
  input wire logic link_pkt_valid,
  input wire logic link_pkt_last,
  output logic link_pkt_ready,
  output logic got_blk,
  output logic [7:0] got_len
);
  logic [7:0] beats_q;
  // ready comes and goes at random; hold stalls the link outright
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) link_pkt_ready <= 1'b0;
    else link_pkt_ready <= !hold && coin;
  end
  // count accepted beats, one report per finished block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beats_q <= 8'h00;
      got_blk <= 1'b0;
      got_len <= 8'h00;
    end else begin
      got_blk <= 1'b0;
      if (link_pkt_valid && link_pkt_ready) begin
        beats_q <= link_pkt_last ? 8'h00 : beats_q + 8'h01;
        got_blk <= link_pkt_last;
        got_len <= beats_q + 8'h01;
      end
    end
  end
endmodule : ibtq_host_model

// [verification/tb_image_block_transfer_queue.sv]
// self-checking bench of the transfer queue
module tb_image_block_transfer_queue;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DP = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic blk_beat_valid, blk_beat_last, capture_running, hold, got_blk;
  logic link_pkt_ready, link_pkt_valid, link_pkt_last;
  logic coin = 1'b1;
  logic [7:0] paddr, got_len;
  logic [31:0] pwdata, prdata, rnd;
  logic [32:0] exp_rd[$];
  logic [32:0] note;
  logic [7:0] exp_len[$];
  int n_fail, checks_done, seed;
  ibtq_top #(.DEPTH(DP), .PKT_BEATS(16'h0004)) dut_u (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .blk_beat_valid, .blk_beat_last, .capture_running, .link_pkt_ready,
    .link_pkt_valid, .link_pkt_last, .irq);
  ibtq_host_model host_u (.pclk, .presetn, .hold, .coin, .link_pkt_valid,
    .link_pkt_last, .link_pkt_ready, .got_blk, .got_len);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // random pacing of the link, so the far side answers slow and fast
  always @(posedge pclk) begin
    rnd = $random(seed);
    coin <= rnd[0];
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen %h wanted %h", $time, g, e);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task miss;
    n_fail++;
    $display("ERROR t=%0t wait ran out", $time);
    close_out();
  endtask : miss
  // oldest note against each read and each received block
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      note = exp_rd.pop_front();
      chk(prdata, note[31:0]);
      chk({31'h0, pslverr}, {31'h0, note[32]});
    end
    if (got_blk) chk({24'h000000, got_len}, {24'h000000, exp_len.pop_front()});
  end
  // one transfer, then an idle cycle so psel is never set twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) miss();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back({a > ibtq_pkg::OFS_STATUS, e});
    apb(1'b0, a, 32'h00000000);
  endtask : rd
  task blk(input int n, input logic fin);
    for (int i = 0; i < n; i++) begin
      blk_beat_valid <= 1'b1;
      blk_beat_last <= fin && (i == n - 1);
      @(posedge pclk);
    end
    blk_beat_valid <= 1'b0;
    blk_beat_last <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : blk
  task until_valid;
    int k;
    k = 0;
    while (link_pkt_valid !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 100) miss();
  endtask : until_valid
  task drain;
    int k;
    k = 0;
    while (exp_len.size() > 0 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 3000) miss();
    repeat (10) @(posedge pclk);
  endtask : drain
  task irq_is(input logic e);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge pclk);
  endtask : irq_is
  initial begin
    seed = 32'h1FE92D72;
    {psel, penable, pwrite, blk_beat_valid, blk_beat_last} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    capture_running = 1'b0;
    hold = 1'b1;
    presetn = 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ibtq_pkg::OFS_CAPACITY, DP);
    rd(ibtq_pkg::OFS_BLOCKS, ibtq_pkg::BLOCKS_RESET);
    rd(ibtq_pkg::OFS_ORDERING, 32'h00000000);
    rd(8'h3C, 32'h00000000);
    apb(1'b1, ibtq_pkg::OFS_POLICY, 32'h00000003);
    rd(ibtq_pkg::OFS_POLICY, 32'h00000000);
    apb(1'b1, ibtq_pkg::OFS_CHANNEL, 32'h00000001);
    $display("test registers done");
    // link stalled: first block stuck, two later arrivals overflow
    exp_len = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07};
    blk(1, 1'b1);
    until_valid();
    for (int i = 2; i < 8; i++) blk(i, 1'b1);
    capture_running <= 1'b1;
    rd(ibtq_pkg::OFS_OCCUPANCY, DP);
    rd(ibtq_pkg::OFS_LOST, 32'h00000002);
    rd(ibtq_pkg::OFS_IRQ_STATUS, 32'h00000001);
    rd(ibtq_pkg::OFS_STATUS, 32'h00000006);
    apb(1'b1, ibtq_pkg::OFS_IRQ_ENABLE, 32'h00000001);
    irq_is(1'b1);
    apb(1'b1, ibtq_pkg::OFS_IRQ_ENABLE, 32'h00000000);
    irq_is(1'b0);
    apb(1'b1, ibtq_pkg::OFS_IRQ_ENABLE, 32'h00000001);
    apb(1'b1, ibtq_pkg::OFS_IRQ_CLEAR, 32'h00000001);
    irq_is(1'b0);
    capture_running <= 1'b0;
    rd(ibtq_pkg::OFS_OCCUPANCY, DP);
    hold <= 1'b0;
    drain();
    rd(ibtq_pkg::OFS_OCCUPANCY, 32'h00000000);
    $display("test overflow done");
    // output must begin once one packet of the block is in
    exp_len.push_back(8'h08);
    blk(4, 1'b0);
    until_valid();
    blk(4, 1'b1);
    drain();
    $display("test early start done");
    apb(1'b1, ibtq_pkg::OFS_POLICY, 32'h00000002);
    apb(1'b1, ibtq_pkg::OFS_STYLE, 32'h00000001);
    apb(1'b1, ibtq_pkg::OFS_BLOCKS, 32'h00000002);
    repeat (3) blk(2, 1'b1);
    rd(ibtq_pkg::OFS_OCCUPANCY, 32'h00000003);
    exp_len = '{8'h02, 8'h02};
    apb(1'b1, ibtq_pkg::OFS_COMMAND, 32'h00000001);
    drain();
    rd(ibtq_pkg::OFS_OCCUPANCY, 32'h00000001);
    rd(ibtq_pkg::OFS_IRQ_STATUS, 32'h00000006);
    $display("test counted burst done");
    apb(1'b1, ibtq_pkg::OFS_STYLE, 32'h00000000);
    exp_len = '{8'h02, 8'h03, 8'h04};
    apb(1'b1, ibtq_pkg::OFS_COMMAND, 32'h00000001);
    blk(3, 1'b1);
    blk(4, 1'b1);
    drain();
    hold <= 1'b1;
    exp_len.push_back(8'h06);
    blk(6, 1'b1);
    until_valid();
    apb(1'b1, ibtq_pkg::OFS_COMMAND, 32'h00000002);
    hold <= 1'b0;
    drain();
    blk(2, 1'b1);
    rd(ibtq_pkg::OFS_OCCUPANCY, 32'h00000001);
    apb(1'b1, ibtq_pkg::OFS_CHANNEL, 32'h00000000);
    rd(ibtq_pkg::OFS_OCCUPANCY, 32'h00000000);
    apb(1'b1, ibtq_pkg::OFS_CHANNEL, 32'h00000001);
    $display("test continuous done");
    apb(1'b1, ibtq_pkg::OFS_POLICY, 32'h00000000);
    apb(1'b1, ibtq_pkg::OFS_COMMAND, 32'h00000002);
    exp_len.push_back(8'h05);
    blk(5, 1'b1);
    drain();
    $display("test basic ignores halt done");
    close_out();
  end
endmodule : tb_image_block_transfer_queue
